// File: pkg/bus_lane_cfg.svh
// Purpose: shared constants for the address, byte-lane and parity link
// Assumes: included by the package, the interface, both link ends and the testbench
// Notes:   widths, lane masks and idle levels of the pins
`ifndef BUS_LANE_CFG_SVH
`define BUS_LANE_CFG_SVH
`define DATA_W      32
`define LANES       4
`define ADDR_W      30
`define ADDR_LO     2
`define INVAL_W     28
`define INVAL_LO    4
`define WIDTH_32    2'h0
`define WIDTH_16    2'h1
`define WIDTH_8     2'h2
`define LANE_ALL    4'hF
`define LANE_16     4'h3
`define LANE_8      4'h1
`define PARITY_FAIL_N_IDLE   1'h1
`define BE_IDLE     4'hF
`define PULL_LEVEL  1'h1
`endif

// File: pkg/bus_lane_pkg.sv
// Purpose: types and lane functions for both link ends
// Assumes: constants come from the cfg header
// Notes:   even parity per byte, lane enables from byte selects and width
`include "bus_lane_cfg.svh"
package bus_lane_pkg;
    typedef logic [`DATA_W-1:0] word_t;
    typedef logic [`LANES-1:0]  lane_t;
    typedef logic [`ADDR_W-1:0] waddr_t;
    typedef logic [1:0]         width_t;

    typedef enum logic [2:0] {
        D_IDLE = 3'b001,
        D_ADDR = 3'b010,
        D_DATA = 3'b100
    } dev_state_t;

    typedef enum logic [2:0] {
        H_IDLE = 3'b001,
        H_WAIT = 3'b010,
        H_RESP = 3'b100
    } host_state_t;

    // one bit per byte, set so each byte plus its bit holds an even count of ones
    function automatic lane_t lane_parity(input word_t d);
        lane_t p;
        p = '0;
        for (int i = 0; i < `LANES; i++) begin
            p[i] = ^d[8*i +: 8];
        end
        return p;
    endfunction

    // active-high lanes: low select bit, limited by the bus width
    function automatic lane_t lane_enable(input lane_t sel_n, input width_t w);
        lane_t m;
        m = `LANE_ALL;
        if (w == `WIDTH_16) begin
            m = `LANE_16;
        end else if (w == `WIDTH_8) begin
            m = `LANE_8;
        end
        return ~sel_n & m;
    endfunction
endpackage

// File: pkg/bus_lane_if.sv
// Purpose: pins between the processor end and the system end
// Assumes: both ends clocked by mclk
// Notes:   shared wires resolved here from the enables, pulled high when idle
`timescale 1ns/1ps
`default_nettype none
`include "bus_lane_cfg.svh"
interface bus_lane_if (
    input wire logic mclk,
    input wire logic rst_b
);
    import bus_lane_pkg::*;
    // processor drives
    waddr_t word_address_lines;
    logic   word_address_oe;
    lane_t  byte_lane_select_n;
    logic   byte_lane_oe;
    word_t  dev_data;
    logic   dev_data_oe;
    lane_t  dev_parity;
    logic   dev_parity_oe;
    logic   parity_fail_n;
    logic   cycle_start_n;
    logic   cycle_write;
    logic   line_fill;
    // system drives
    logic [`INVAL_W-1:0] inval_address;
    logic   inval_address_oe;
    word_t  host_data;
    logic   host_data_oe;
    lane_t  host_parity;
    logic   host_parity_oe;
    logic   ready_n;
    logic   bus_hold;
    logic   address_hold;
    logic   inval_strobe;
    width_t lane_width;
    // resolved wires
    waddr_t addr_bus;
    word_t  data_lines;
    lane_t  lane_parity_bits;

    assign addr_bus[`ADDR_W-1:`INVAL_LO-`ADDR_LO] =
        word_address_oe ? word_address_lines[`ADDR_W-1:`INVAL_LO-`ADDR_LO] :
        inval_address_oe ? inval_address : {`INVAL_W{`PULL_LEVEL}};
    assign addr_bus[`INVAL_LO-`ADDR_LO-1:0] =
        word_address_oe ? word_address_lines[`INVAL_LO-`ADDR_LO-1:0] : {2{`PULL_LEVEL}};
    assign data_lines = dev_data_oe ? dev_data :
                        host_data_oe ? host_data : {`DATA_W{`PULL_LEVEL}};
    assign lane_parity_bits = dev_parity_oe ? dev_parity :
                              host_parity_oe ? host_parity : {`LANES{`PULL_LEVEL}};

    modport device (
        input  mclk, rst_b, addr_bus, data_lines, lane_parity_bits,
        input  ready_n, bus_hold, address_hold, inval_strobe, lane_width,
        output word_address_lines, word_address_oe, byte_lane_select_n, byte_lane_oe,
        output dev_data, dev_data_oe, dev_parity, dev_parity_oe, parity_fail_n,
        output cycle_start_n, cycle_write, line_fill
    );
    modport host (
        input  mclk, rst_b, addr_bus, data_lines, lane_parity_bits,
        input  byte_lane_select_n, parity_fail_n, cycle_start_n, cycle_write, line_fill,
        output inval_address, inval_address_oe, host_data, host_data_oe,
        output host_parity, host_parity_oe, ready_n, bus_hold, address_hold,
        output inval_strobe, lane_width
    );
endinterface
`default_nettype wire

// File: rtl/bus_lane_host.sv
// Purpose: system end: memory with wait states, hold and invalidate drive
// Assumes: one transfer per processor cycle
// Notes:   disabled read lanes return zero data with a deliberately odd parity bit
`timescale 1ns/1ps
`default_nettype none
`include "bus_lane_cfg.svh"
module bus_lane_host #(
    parameter int DEPTH = 16,
    parameter int WAIT  = 1
) (
    // link
    bus_lane_if.host                lnk,
    // controls
    input  wire logic               hold_req,
    input  wire logic               ahold_req,
    input  wire logic               inval_req,
    input  wire logic [`INVAL_W-1:0] inval_line,
    input  wire bus_lane_pkg::width_t width_sel,
    input  wire bus_lane_pkg::lane_t  parity_inject,
    // status
    output logic                    write_seen,
    output logic                    write_parity_bad,
    output logic                    fail_seen
);
    import bus_lane_pkg::*;
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        host_state_t st;
        logic [3:0]  cnt;
        logic        wr;
        logic        fill;
        lane_t       sel_n;
        logic [AW-1:0] idx;
        word_t       d_o;
        logic        d_oe;
        lane_t       p_o;
        logic        ready_n;
        logic        hold;
        logic        ahold;
        logic        inval;
        logic        inval_oe;
        logic [`INVAL_W-1:0] inval_a;
        width_t      width;
        logic        wseen;
        logic        wbad;
        logic        fseen;
    } host_reg_t;

    host_reg_t r;
    host_reg_t next_r;
    word_t     mem [DEPTH];
    word_t     rd;
    lane_t     en;

    // lanes to serve; a line fill treats every lane as enabled
    always_comb begin
        en = r.fill ? `LANE_ALL : lane_enable(r.sel_n, r.width);
        rd = '0;
        for (int i = 0; i < `LANES; i++) begin
            if (en[i]) begin
                rd[8*i +: 8] = mem[r.idx][8*i +: 8];
            end
        end
    end

    // transfer sequencing
    always_comb begin
        next_r          = r;
        next_r.ready_n  = 1'b1;
        next_r.wseen    = 1'b0;
        next_r.wbad     = 1'b0;
        next_r.fseen    = ~lnk.parity_fail_n;
        next_r.hold     = hold_req;
        next_r.ahold    = ahold_req;
        next_r.inval    = inval_req;
        next_r.inval_oe = inval_req & (hold_req | ahold_req);
        next_r.inval_a  = inval_line;
        next_r.width    = width_sel;
        unique case (r.st)
            H_IDLE: begin
                if (!lnk.cycle_start_n) begin
                    next_r.wr    = lnk.cycle_write;
                    next_r.fill  = lnk.line_fill;
                    next_r.sel_n = lnk.byte_lane_select_n;
                    next_r.idx   = lnk.addr_bus[AW-1:0];
                    next_r.cnt   = 4'(WAIT);
                    next_r.st    = H_WAIT;
                end
            end
            H_WAIT: begin
                if (r.cnt == 4'h0) begin
                    next_r.ready_n = 1'b0;
                    next_r.d_oe    = ~r.wr;
                    next_r.d_o     = rd;
                    // even parity on served lanes, odd on idle ones
                    next_r.p_o = (lane_parity(rd) & en | ~en) ^ parity_inject;
                    next_r.st      = H_RESP;
                end else begin
                    next_r.cnt = r.cnt - 4'h1;
                end
            end
            H_RESP: begin
                next_r.d_oe  = 1'b0;
                next_r.wseen = r.wr;
                next_r.wbad  = r.wr & |((lane_parity(lnk.data_lines) ^ lnk.lane_parity_bits) & en);
                next_r.st    = H_IDLE;
            end
        endcase
    end

    always_ff @(posedge lnk.mclk or negedge lnk.rst_b) begin
        if (!lnk.rst_b) begin
            r         <= '0;
            r.st      <= H_IDLE;
            r.ready_n <= 1'b1;
            r.sel_n   <= `BE_IDLE;
        end else begin
            r <= next_r;
        end
    end

    // memory keeps only the lanes the processor enabled
    always_ff @(posedge lnk.mclk) begin
        if (r.st == H_RESP && r.wr) begin
            for (int i = 0; i < `LANES; i++) begin
                if (en[i]) begin
                    mem[r.idx][8*i +: 8] <= lnk.data_lines[8*i +: 8];
                end
            end
        end
    end

    assign lnk.host_data        = r.d_o;
    assign lnk.host_data_oe     = r.d_oe;
    assign lnk.host_parity      = r.p_o;
    assign lnk.host_parity_oe   = r.d_oe;
    assign lnk.ready_n          = r.ready_n;
    assign lnk.bus_hold         = r.hold;
    assign lnk.address_hold     = r.ahold;
    assign lnk.inval_strobe     = r.inval;
    assign lnk.inval_address    = r.inval_a;
    assign lnk.inval_address_oe = r.inval_oe;
    assign lnk.lane_width       = r.width;
    assign write_seen           = r.wseen;
    assign write_parity_bad     = r.wbad;
    assign fail_seen            = r.fseen;
endmodule
`default_nettype wire

// File: rtl/bus_lane_device.sv
// Purpose: processor end of the address, byte-lane and data parity pins
// Assumes: single transfer per request; hold honoured between cycles
// Notes:   read data goes to the user untouched; parity only feeds the status pin and parity_error
//          a hold in mid-cycle floats pins; the cycle still ends
// Behaviour
// - everything timed on rising mclk edge
// - upper address lines accept invalidation addresses
// - float word address during hold states
// - system treats all lanes enabled on fill
// - byte selects low active, floated in bus hold
// - each select covers one data byte
// - write data driven from second clock
// - one parity bit per written byte
// - system returns even parity with read data
// - read parity never alters delivered data
// - parity pins driven from second write clock
// - status pin low clock after ready
// - check only enabled and width-covered lanes
// - status pin high otherwise, never floated
`timescale 1ns/1ps
`default_nettype none
`include "bus_lane_cfg.svh"
module bus_lane_device (
    // link
    bus_lane_if.device              lnk,

    // request
    input  wire logic               req,
    input  wire logic               req_write,
    input  wire logic               req_fill,
    input  wire bus_lane_pkg::waddr_t req_addr,
    input  wire bus_lane_pkg::lane_t  req_lanes,
    input  wire bus_lane_pkg::word_t  req_wdata,

    // answer
    output logic                    busy,
    output logic                    done,
    output bus_lane_pkg::word_t     rd_data,
    output logic                    parity_error,

    // invalidation
    output logic                    inval_valid,
    output logic [`INVAL_W-1:0]     inval_line
);
    import bus_lane_pkg::*;

    // ====================================================================
    // state
    typedef struct packed {
        dev_state_t st;
        logic       wr;
        logic       fill;

        // address and lanes
        waddr_t     a_o;
        logic       a_oe;
        lane_t      sel_n;
        logic       sel_oe;

        // data and parity
        word_t      d_o;
        logic       d_oe;
        lane_t      p_o;
        logic       strobe_n;
        logic       pf_n;

        // user side
        logic       busy;
        logic       done;
        word_t      rdata;
        logic       perr;
        logic       iv;
        logic [`INVAL_W-1:0] iline;
    } dev_reg_t;

    dev_reg_t r;
    dev_reg_t next_r;
    logic     floating;
    lane_t    lane_en;
    lane_t    lane_bad;

    // ====================================================================
    // read check terms
    // hold from either source takes the address pins off the bus
    always_comb begin
        floating = lnk.bus_hold | lnk.address_hold;

        lane_en  = lane_enable(r.sel_n, lnk.lane_width);
        // per-lane mismatch against even parity, idle lanes masked off
        lane_bad = (lane_parity(lnk.data_lines) ^ lnk.lane_parity_bits) & lane_en;
    end

    // ====================================================================
    // cycle sequencing
    always_comb begin
        next_r       = r;
        next_r.done  = 1'b0;
        next_r.perr  = 1'b0;
        next_r.iv    = 1'b0;

        // status pin stays high outside its one valid clock
        next_r.pf_n  = `PARITY_FAIL_N_IDLE;
        // address pins released whenever either hold is up
        next_r.a_oe  = r.busy & ~floating;
        // byte selects only answer to bus hold
        next_r.sel_oe = r.busy & ~lnk.bus_hold;

        // while the address pins float the system may push a line to kill
        if (floating && lnk.inval_strobe) begin
            next_r.iv    = 1'b1;
            next_r.iline = lnk.addr_bus[`ADDR_W-1:`INVAL_LO-`ADDR_LO];
        end

        unique case (r.st)
            D_IDLE: begin
                // a new cycle waits for both holds to drop
                if (req && !floating) begin
                    next_r.st       = D_ADDR;
                    next_r.busy     = 1'b1;
                    next_r.wr       = req_write;
                    next_r.fill     = req_fill & ~req_write;
                    next_r.a_o      = req_addr;
                    next_r.a_oe     = 1'b1;

                    // lane i is data byte i, so bit 3 owns the top byte
                    next_r.sel_n    = ~req_lanes;
                    next_r.sel_oe   = 1'b1;

                    next_r.strobe_n = 1'b0;
                    // latched once; the user bus may move
                    next_r.d_o      = req_wdata;
                end
            end

            D_ADDR: begin
                // first clock is address only; data and parity follow
                next_r.strobe_n = 1'b1;
                next_r.d_oe     = r.wr;
                next_r.p_o      = lane_parity(r.d_o);
                next_r.st       = D_DATA;
            end

            D_DATA: begin
                // data and parity stay on every clock until ready
                if (!lnk.ready_n) begin
                    next_r.st     = D_IDLE;
                    next_r.busy   = 1'b0;
                    next_r.done   = 1'b1;
                    next_r.d_oe   = 1'b0;
                    next_r.a_oe   = 1'b0;
                    next_r.sel_oe = 1'b0;
                    next_r.fill   = 1'b0;

                    // a write leaves the status pin high
                    if (!r.wr) begin
                        // data passes through untouched by the check
                        next_r.rdata = lnk.data_lines;
                        // error if any enabled lane fails
                        next_r.pf_n  = ~(|lane_bad);
                        next_r.perr  = |lane_bad;
                    end
                end
            end
        endcase
    end

    // ====================================================================
    // registers, all on the rising edge
    // reset: enables low, status pin high
    always_ff @(posedge lnk.mclk or negedge lnk.rst_b) begin
        if (!lnk.rst_b) begin
            r          <= '0;
            r.st       <= D_IDLE;
            r.sel_n    <= `BE_IDLE;
            r.strobe_n <= 1'b1;
            r.pf_n     <= `PARITY_FAIL_N_IDLE;
        end else begin
            r <= next_r;
        end
    end

    // ====================================================================
    // pins and user outputs, each straight from a flop
    assign lnk.word_address_lines = r.a_o;
    assign lnk.word_address_oe    = r.a_oe;
    assign lnk.byte_lane_select_n = r.sel_n;
    assign lnk.byte_lane_oe       = r.sel_oe;
    assign lnk.dev_data           = r.d_o;
    assign lnk.dev_data_oe        = r.d_oe;
    // parity rides with the data enable, so timing matches exactly
    assign lnk.dev_parity         = r.p_o;
    assign lnk.dev_parity_oe      = r.d_oe;

    assign lnk.parity_fail_n      = r.pf_n;

    assign lnk.cycle_start_n      = r.strobe_n;
    assign lnk.cycle_write        = r.wr;
    assign lnk.line_fill          = r.fill;

    // user outputs
    assign busy                   = r.busy;
    assign done                   = r.done;
    assign rd_data                = r.rdata;
    assign parity_error           = r.perr;

    assign inval_valid            = r.iv;
    assign inval_line             = r.iline;
endmodule
`default_nettype wire

// File: tb/bus_lane_monitor.sv
// Purpose: checker on the pins between the processor end and the system end
// Assumes: one clock mclk, reset rst_b asynchronous and low active
// Notes:   parity expectations are computed bytewise here, not from the package
`timescale 1ns/1ps
`default_nettype none
module bus_lane_monitor (
    // clock and reset
    input wire logic                 mclk,
    input wire logic                 rst_b,
    // processor end
    input wire logic                 word_address_oe,
    input wire logic                 byte_lane_oe,
    input wire bus_lane_pkg::lane_t  byte_lane_select_n,
    input wire bus_lane_pkg::word_t  dev_data,
    input wire logic                 dev_data_oe,
    input wire bus_lane_pkg::lane_t  dev_parity,
    input wire logic                 dev_parity_oe,
    input wire logic                 parity_fail_n,
    input wire logic                 cycle_start_n,
    input wire logic                 cycle_write,
    // system end and resolved pins
    input wire logic                 ready_n,
    input wire logic                 bus_hold,
    input wire logic                 address_hold,
    input wire bus_lane_pkg::width_t lane_width,
    input wire bus_lane_pkg::word_t  data_lines,
    input wire bus_lane_pkg::lane_t  lane_parity_bits
);
    import bus_lane_pkg::*;
    // ====================
    // lane checks rebuilt from the pins
    logic [3:0] wmask;
    logic [3:0] bad_lane;
    logic [3:0] calc_par;
    wire logic  rd_ready = !ready_n && !cycle_write;
    wire logic  rd_err   = |(bad_lane & ~byte_lane_select_n & wmask);

    // width codes narrow the lanes that count; disabled lanes may carry junk parity
    always_comb begin
        wmask = (lane_width == 2'h1) ? 4'h3 : ((lane_width == 2'h2) ? 4'h1 : 4'hF);
        for (int i = 0; i < 4; i++) begin
            bad_lane[i] = (^data_lines[8*i +: 8]) ^ lane_parity_bits[i];
            calc_par[i] = ^dev_data[8*i +: 8];
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);

    // ====================
    // assertions
    a_parity_fail_n_status_value: assert property (
        rd_ready |=> parity_fail_n == !$past(rd_err)) else $error("status pin wrong after read");
    a_parity_fail_n_only_after_read: assert property (
        !parity_fail_n |-> $past(rd_ready)) else $error("status pin low outside read status slot");
    a_parity_fail_n_one_clock: assert property (
        !parity_fail_n |=> parity_fail_n) else $error("status pin low for more than one clock");
    a_write_data_start: assert property (
        !cycle_start_n && cycle_write |=> dev_data_oe) else $error("write data not driven in clock two");
    a_write_data_held: assert property (
        dev_data_oe && ready_n |=> dev_data_oe && $stable(dev_data))
        else $error("write data dropped or changed before ready");
    a_write_parity_even: assert property (
        dev_parity_oe |-> dev_parity == calc_par)
        else $error("write parity not even per byte");
    a_parity_with_data: assert property (
        dev_parity_oe == dev_data_oe) else $error("parity drive differs from data drive");
    a_addr_float_hold: assert property (
        $past(bus_hold) || $past(address_hold) |-> !word_address_oe)
        else $error("address driven during hold");
    a_lane_float_hold: assert property (
        $past(bus_hold) |-> !byte_lane_oe) else $error("byte selects driven during bus hold");

    // main scenarios reached
    c_read_error: cover property (rd_ready && rd_err);
    c_read_clean: cover property (rd_ready && !rd_err);
    c_write_done: cover property (dev_data_oe && !ready_n);
    c_addr_hold: cover property (address_hold && !word_address_oe);
endmodule
`default_nettype wire

// File: tb/tb_bus_lane_parity_interface.sv
// Purpose: drives both link ends through their user ports and checks results
// Assumes: host built with one wait state; memory indexed by low word address bits
// Notes:   pin timing is judged by the monitor, data and status paths here
`timescale 1ns/1ps
`default_nettype none
`include "bus_lane_cfg.svh"
module tb_bus_lane_parity_interface;
    import bus_lane_pkg::*;
    // ====================
    // stimulus and observed signals
    logic        mclk, rst_b, req, req_write, req_fill, hold_req, ahold_req, inval_req;
    logic        busy, done, parity_error, inval_valid, write_seen, write_parity_bad;
    logic        got_err, got_ws, got_wbad, fail_seen;
    waddr_t      req_addr;
    lane_t       req_lanes, parity_inject;
    word_t       req_wdata, rd_data;
    width_t      width_sel;
    logic [27:0] inval_target, inval_got;
    int          error_cnt, check_count, n;

    bus_lane_if u_bus_lane_if (.mclk(mclk), .rst_b(rst_b));
    bus_lane_device u_bus_lane_device (.lnk(u_bus_lane_if), .req(req), .req_write(req_write),
        .req_fill(req_fill), .req_addr(req_addr), .req_lanes(req_lanes), .req_wdata(req_wdata),
        .busy(busy), .done(done), .rd_data(rd_data), .parity_error(parity_error),
        .inval_valid(inval_valid), .inval_line(inval_got));
    bus_lane_host #(.DEPTH(16), .WAIT(1)) u_bus_lane_host (.lnk(u_bus_lane_if),
        .hold_req(hold_req), .ahold_req(ahold_req), .inval_req(inval_req),
        .inval_line(inval_target), .width_sel(width_sel), .parity_inject(parity_inject),
        .write_seen(write_seen), .write_parity_bad(write_parity_bad), .fail_seen(fail_seen));
    bus_lane_monitor u_bus_lane_monitor (.mclk(mclk), .rst_b(rst_b),
        .word_address_oe(u_bus_lane_if.word_address_oe),
        .byte_lane_oe(u_bus_lane_if.byte_lane_oe),
        .byte_lane_select_n(u_bus_lane_if.byte_lane_select_n),
        .dev_data(u_bus_lane_if.dev_data), .dev_data_oe(u_bus_lane_if.dev_data_oe),
        .dev_parity(u_bus_lane_if.dev_parity), .dev_parity_oe(u_bus_lane_if.dev_parity_oe),
        .parity_fail_n(u_bus_lane_if.parity_fail_n),
        .cycle_start_n(u_bus_lane_if.cycle_start_n), .cycle_write(u_bus_lane_if.cycle_write),
        .ready_n(u_bus_lane_if.ready_n), .bus_hold(u_bus_lane_if.bus_hold),
        .address_hold(u_bus_lane_if.address_hold), .lane_width(u_bus_lane_if.lane_width),
        .data_lines(u_bus_lane_if.data_lines),
        .lane_parity_bits(u_bus_lane_if.lane_parity_bits));

    // 50 MHz clock
    always #10 mclk = ~mclk;

    // ====================
    // compare, report and transfer tasks
    task automatic chk_word(input word_t got, input word_t exp, input string msg);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic chk_flag(input logic got, input logic exp, input string msg);
        chk_word({31'h0, got}, {31'h0, exp}, msg);
    endtask

    task automatic tend(input string name);
        $display("test %s finished, mismatches so far %0d", name, error_cnt);
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // host controls go out with the request so they settle before the data phase
    task automatic xfer(input logic wr, input logic fill, input waddr_t a, input lane_t ln,
                        input word_t wd, input lane_t inj, input width_t wid);
        @(negedge mclk);
        req = 1'h1;
        req_write = wr;
        req_fill = fill;
        req_addr = a;
        req_lanes = ln;
        req_wdata = wd;
        parity_inject = inj;
        width_sel = wid;
        @(negedge mclk);
        req = 1'h0;
        for (n = 0; n < 40 && done !== 1'h1; n++) begin
            @(posedge mclk);
            #1;
        end
        if (done !== 1'h1) begin
            error_cnt++;
            $display("unexpected at %0t: transfer never completed", $time);
            results();
        end
        got_err = parity_error;
        got_ws = write_seen;
        got_wbad = write_parity_bad;
    endtask

    // ====================
    // test sequence
    initial begin
        mclk = 1'h0;
        rst_b = 1'h0;
        {req, req_write, req_fill, hold_req, ahold_req, inval_req} = 6'h00;
        req_addr = 30'h0;
        req_lanes = 4'h0;
        req_wdata = 32'h0;
        parity_inject = 4'h0;
        width_sel = 2'h0;
        inval_target = 28'h0;
        error_cnt = 0;
        check_count = 0;
        repeat (3) @(negedge mclk);
        rst_b = 1'h1;
        // back-to-back writes with mixed byte parity, then read back
        xfer(1'h1, 1'h0, 30'h1, 4'hF, 32'hA7C3_1F81, 4'h0, 2'h0);
        chk_flag(got_ws, 1'h1, "write reached system");
        chk_flag(got_wbad, 1'h0, "write parity");
        xfer(1'h1, 1'h0, 30'h2, 4'hF, 32'h1234_5678, 4'h0, 2'h0);
        chk_flag(got_wbad, 1'h0, "second write parity");
        xfer(1'h0, 1'h0, 30'h1, 4'hF, 32'h0, 4'h0, 2'h0);
        chk_word(rd_data, 32'hA7C3_1F81, "read back");
        chk_flag(got_err, 1'h0, "clean read status");
        xfer(1'h0, 1'h0, 30'h1, 4'h5, 32'h0, 4'h0, 2'h0);
        chk_word(rd_data, 32'h00C3_0081, "two lane read");
        chk_flag(got_err, 1'h0, "odd parity on idle lanes ignored");
        tend("write_read");
        // one bad lane at a time: flagged when enabled, ignored when not
        for (int i = 0; i < 4; i++) begin
            xfer(1'h0, 1'h0, 30'h1, 4'hF, 32'h0, lane_t'(1 << i), 2'h0);
            chk_flag(got_err, 1'h1, "bad enabled lane");
            chk_word(rd_data, 32'hA7C3_1F81, "data kept despite bad parity");
            @(posedge mclk);
            #1;
            chk_flag(fail_seen, 1'h1, "system saw status low");
            xfer(1'h0, 1'h0, 30'h1, ~lane_t'(1 << i), 32'h0, lane_t'(1 << i), 2'h0);
            chk_flag(got_err, 1'h0, "bad disabled lane");
        end
        tend("lane_errors");
        // narrow bus widths drop the upper lanes from the check
        xfer(1'h0, 1'h0, 30'h1, 4'hF, 32'h0, 4'hC, 2'h1);
        chk_flag(got_err, 1'h0, "16 bit upper lanes");
        xfer(1'h0, 1'h0, 30'h1, 4'hF, 32'h0, 4'h2, 2'h1);
        chk_flag(got_err, 1'h1, "16 bit lane one");
        xfer(1'h0, 1'h0, 30'h1, 4'hF, 32'h0, 4'h2, 2'h2);
        chk_flag(got_err, 1'h0, "8 bit lane one");
        xfer(1'h0, 1'h0, 30'h1, 4'hF, 32'h0, 4'h1, 2'h2);
        chk_flag(got_err, 1'h1, "8 bit lane zero");
        tend("bus_width");
        // first transfer of a fill returns the whole word
        xfer(1'h0, 1'h1, 30'h2, 4'h1, 32'h0, 4'h0, 2'h0);
        chk_word(rd_data, 32'h1234_5678, "fill word");
        chk_flag(got_err, 1'h0, "fill status");
        tend("line_fill");
        // invalidation under address hold, then a refused request under bus hold
        @(negedge mclk);
        ahold_req = 1'h1;
        inval_req = 1'h1;
        inval_target = 28'hABC_DE12;
        for (n = 0; n < 20 && inval_valid !== 1'h1; n++) begin
            @(posedge mclk);
            #1;
        end
        chk_flag(inval_valid, 1'h1, "invalidation seen");
        if (inval_valid !== 1'h1) begin
            results();
        end
        chk_word({4'h0, inval_got}, 32'h0ABC_DE12, "invalidation line");
        @(negedge mclk);
        {ahold_req, inval_req, hold_req} = 3'h1;
        repeat (3) @(negedge mclk);
        req = 1'h1;
        @(negedge mclk);
        req = 1'h0;
        repeat (4) @(negedge mclk);
        chk_flag(busy, 1'h0, "request ignored in hold");
        hold_req = 1'h0;
        repeat (3) @(negedge mclk);
        // bus hold raised in mid-read floats the pins, the read still ends
        fork
            xfer(1'h0, 1'h0, 30'h2, 4'hF, 32'h0, 4'h0, 2'h0);
            begin
                repeat (2) @(negedge mclk);
                hold_req = 1'h1;
            end
        join
        @(negedge mclk);
        hold_req = 1'h0;
        chk_word(rd_data, 32'h1234_5678, "read after hold");
        tend("hold");
        results();
    end
endmodule
`default_nettype wire
